//--- async_serial_pkg.sv
package async_serial_pkg;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [7:0] ADDR_STATUS_ONE  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK    = 8'h08;
	localparam logic [7:0] ADDR_DATA_BUFFER = 8'h0C;
	localparam logic [7:0] ADDR_BAUD_DIV    = 8'h10;

	// Field positions of control_one.
	localparam int CTL_TX_INVERT = 0;
	localparam int CTL_NINE_BIT  = 1;
	localparam int CTL_TX_ENABLE = 2;
	localparam int CTL_RX_ENABLE = 3;
	localparam int CTL_W         = 4;
	localparam logic [3:0] CONTROL_RESET = 4'h0;

	// Field positions of status_one and of the mask register.
	localparam int ST_TX_EMPTY    = 0;
	localparam int ST_TX_COMPLETE = 1;
	localparam int ST_RX_FULL     = 2;
	localparam int ST_NOISE       = 3;
	localparam int ST_FRAMING     = 4;
	localparam int ST_BREAK       = 5;
	localparam int ST_W           = 6;
	localparam logic [5:0] STATUS_RESET = 6'h03;
	localparam logic [5:0] MASK_RESET   = 6'h00;

	// Oversample tick positions within one bit period.
	localparam logic [4:0] POS_FIRST   = 5'h01;
	localparam logic [4:0] POS_VERIFY1 = 5'h03;
	localparam logic [4:0] POS_VERIFY2 = 5'h05;
	localparam logic [4:0] POS_VERIFY3 = 5'h07;
	localparam logic [4:0] POS_VOTE1   = 5'h08;
	localparam logic [4:0] POS_VOTE2   = 5'h09;
	localparam logic [4:0] POS_VOTE3   = 5'h0A;
	localparam logic [4:0] POS_LAST    = 5'h10;
	localparam logic [3:0] TX_POS_LAST = 4'hF;

	// Timing: ticks per baud and default divider from the system clock.
	localparam int CLK_HZ       = 125_000_000;
	localparam int BAUD_DEFAULT = 115_200;
	localparam int OVERSAMPLE   = 16;
	localparam int DIV_DEFAULT  = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE) - 1;

	// AXI write and read responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

//--- async_serial_unit.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module async_serial_unit #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              serial_in,
	output logic                   serial_out,
	output logic                   irq
);
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              aw_have_q, w_have_q, do_write;
	logic [3:0]        control_q;
	logic [5:0]        status_q, mask_q, status_set, status_clr;
	logic [15:0]       baud_div_q, div_cnt_q;
	logic              tick_q;
	logic [8:0]        tx_buf_q;
	logic              tx_buf_full_q, tx_busy_q, tx_load, tx_done, data_wr;
	logic [10:0]       tx_shift_q;
	logic [3:0]        tx_bits_q, tx_rt_q;
	logic [2:0]        rx_sync_q;
	logic              rx_level_q, rx_prev_q;
	async_serial_pkg::rx_state_t rx_state_q;
	logic [4:0]        rx_rt_q, rx_pos, rx_age_q, rx_age_d;
	logic [1:0]        rx_ones_q;
	logic [2:0]        rx_samp_q, rx_samp_d;
	logic [8:0]        rx_shift_q, rx_word, rx_data_q;
	logic [3:0]        rx_bit_q;
	logic              rx_cur_q, rx_last_q, rx_noise_q;
	logic              rx_done_q, rx_fe_q, rx_nf_q, rx_brk_q;
	logic              nine_bit;
	logic [31:0]       wr_lanes;

	function automatic logic majority3(input logic [2:0] s);
		majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	function automatic logic disagree3(input logic [2:0] s);
		disagree3 = (|s) & ~(&s);
	endfunction

	function automatic logic [31:0] lanes(input logic [3:0] strb);
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	assign nine_bit = control_q[async_serial_pkg::CTL_NINE_BIT];

	// Bit mask of the byte lanes enabled by the stored write strobes.
	assign wr_lanes = lanes(w_strb_q);

	// Write channel: address and data are taken independently, either may come first.
	assign do_write = aw_have_q & w_have_q & ~bvalid;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_addr_q <= '0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= async_serial_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				awready   <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				wready   <= 1'b0;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= (aw_addr_q > ADDR_W'(async_serial_pkg::ADDR_BAUD_DIV) ||
				           aw_addr_q[1:0] != 2'h0) ? async_serial_pkg::RESP_SLVERR
				                                   : async_serial_pkg::RESP_OKAY;
			end
			if (bvalid && bready) begin
				bvalid    <= 1'b0;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				awready   <= 1'b1;
				wready    <= 1'b1;
			end
		end
	end

	// Read channel: one read in flight, answered one cycle after the address is taken.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= async_serial_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= async_serial_pkg::RESP_OKAY;
			case (araddr)
				ADDR_W'(async_serial_pkg::ADDR_CONTROL_ONE): rdata <= {28'h0, control_q};
				ADDR_W'(async_serial_pkg::ADDR_STATUS_ONE):  rdata <= {26'h0, status_q};
				ADDR_W'(async_serial_pkg::ADDR_IRQ_MASK):    rdata <= {26'h0, mask_q};
				ADDR_W'(async_serial_pkg::ADDR_DATA_BUFFER): rdata <= {23'h0, rx_data_q};
				ADDR_W'(async_serial_pkg::ADDR_BAUD_DIV):    rdata <= {16'h0, baud_div_q};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= async_serial_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Software-written configuration; byte strobes gate each lane.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control_q  <= async_serial_pkg::CONTROL_RESET;
			mask_q     <= async_serial_pkg::MASK_RESET;
			baud_div_q <= 16'(async_serial_pkg::DIV_DEFAULT);
		end else if (do_write) begin
			if (aw_addr_q == ADDR_W'(async_serial_pkg::ADDR_CONTROL_ONE) && w_strb_q[0])
				control_q <= w_data_q[3:0];
			if (aw_addr_q == ADDR_W'(async_serial_pkg::ADDR_IRQ_MASK) && w_strb_q[0])
				mask_q <= w_data_q[5:0];
			if (aw_addr_q == ADDR_W'(async_serial_pkg::ADDR_BAUD_DIV))
				baud_div_q <= (baud_div_q & ~wr_lanes[15:0]) |
				              (w_data_q[15:0] & wr_lanes[15:0]);
		end
	end

	// Divider that makes the oversample tick, sixteen per bit time.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_q <= 16'h0000;
			tick_q    <= 1'b0;
		end else if (div_cnt_q == 16'h0000) begin
			div_cnt_q <= baud_div_q;
			tick_q    <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q - 16'h0001;
			tick_q    <= 1'b0;
		end
	end

	// Status flags: hardware sets win over a write-one-to-clear in the same cycle.
	assign data_wr = do_write && w_strb_q[0] &&
	                 aw_addr_q == ADDR_W'(async_serial_pkg::ADDR_DATA_BUFFER);
	always_comb begin
		status_set = 6'h00;
		status_set[async_serial_pkg::ST_TX_EMPTY]    = tx_load;
		status_set[async_serial_pkg::ST_TX_COMPLETE] = tx_done && !tx_buf_full_q;
		status_set[async_serial_pkg::ST_RX_FULL]     = rx_done_q;
		status_set[async_serial_pkg::ST_NOISE]       = rx_done_q && rx_nf_q;
		status_set[async_serial_pkg::ST_FRAMING]     = rx_done_q && rx_fe_q;
		status_set[async_serial_pkg::ST_BREAK]       = rx_done_q && rx_brk_q;
		status_clr = 6'h00;
		if (do_write && w_strb_q[0] &&
		    aw_addr_q == ADDR_W'(async_serial_pkg::ADDR_STATUS_ONE))
			status_clr = w_data_q[5:0];
		if (data_wr) begin
			status_clr[async_serial_pkg::ST_TX_EMPTY]    = 1'b1;
			status_clr[async_serial_pkg::ST_TX_COMPLETE] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= async_serial_pkg::STATUS_RESET;
			irq      <= 1'b0;
		end else begin
			status_q <= (status_q & ~status_clr) | status_set;
			irq      <= |(status_q & mask_q);
		end
	end

	// Transmitter: buffer, then an 11-bit shifter moved once per sixteen ticks.
	assign tx_load = tx_buf_full_q && !tx_busy_q && tick_q &&
	                 control_q[async_serial_pkg::CTL_TX_ENABLE];
	assign tx_done = tx_busy_q && tick_q && tx_rt_q == async_serial_pkg::TX_POS_LAST &&
	                 tx_bits_q == 4'h1;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf_q      <= 9'h000;
			tx_buf_full_q <= 1'b0;
			tx_busy_q     <= 1'b0;
			tx_shift_q    <= 11'h7FF;
			tx_bits_q     <= 4'h0;
			tx_rt_q       <= 4'h0;
			serial_out    <= 1'b1;
		end else begin
			if (data_wr) begin
				tx_buf_q      <= w_data_q[8:0];
				tx_buf_full_q <= 1'b1;
			end else if (tx_load) begin
				tx_buf_full_q <= 1'b0;
			end
			if (tx_load) begin
				tx_busy_q  <= 1'b1;
				tx_rt_q    <= 4'h0;
				tx_shift_q <= nine_bit ? {1'b1, tx_buf_q, 1'b0}
				                       : {2'h3, tx_buf_q[7:0], 1'b0};
				tx_bits_q  <= nine_bit ? 4'hB : 4'hA;
			end else if (tx_busy_q && tick_q) begin
				tx_rt_q <= tx_rt_q + 4'h1;
				if (tx_rt_q == async_serial_pkg::TX_POS_LAST) begin
					tx_shift_q <= {1'b1, tx_shift_q[10:1]};
					tx_bits_q  <= tx_bits_q - 4'h1;
					if (tx_bits_q == 4'h1)
						tx_busy_q <= 1'b0;
				end
			end
			// Idle is a one on the line; inversion applies to every level.
			serial_out <= (tx_busy_q ? tx_shift_q[0] : 1'b1) ^
			              control_q[async_serial_pkg::CTL_TX_INVERT];
		end
	end

	// Receive pin filter: three flops, the level moves only when the last two agree.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_q  <= 3'h7;
			rx_level_q <= 1'b1;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], serial_in};
			if (rx_sync_q[1] == rx_sync_q[2])
				rx_level_q <= rx_sync_q[2];
		end
	end

	// Tick position, sample window and age of the last falling edge seen.
	always_comb begin
		rx_pos    = (rx_rt_q == async_serial_pkg::POS_LAST) ? async_serial_pkg::POS_FIRST
		                                                    : rx_rt_q + 5'h01;
		rx_samp_d = {rx_samp_q[1:0], rx_level_q};
		if (rx_prev_q && !rx_level_q)
			rx_age_d = async_serial_pkg::POS_FIRST;
		else
			rx_age_d = (rx_age_q == 5'h1F) ? rx_age_q : rx_age_q + 5'h01;
		rx_word = nine_bit ? rx_shift_q : {rx_shift_q[8], rx_shift_q[8:1]};
	end

	// Receive engine, advanced on each oversample tick.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_q <= async_serial_pkg::RX_IDLE;
			rx_rt_q    <= 5'h00;
			rx_ones_q  <= 2'h0;
			rx_samp_q  <= 3'h0;
			rx_shift_q <= 9'h000;
			rx_bit_q   <= 4'h0;
			rx_cur_q   <= 1'b0;
			rx_last_q  <= 1'b0;
			rx_noise_q <= 1'b0;
			rx_prev_q  <= 1'b1;
			rx_age_q   <= 5'h1F;
			rx_done_q  <= 1'b0;
			rx_fe_q    <= 1'b0;
			rx_nf_q    <= 1'b0;
			rx_brk_q   <= 1'b0;
			rx_data_q  <= 9'h000;
		end else begin
			rx_done_q <= 1'b0;
			if (tick_q) begin
				rx_prev_q <= rx_level_q;
				rx_age_q  <= rx_age_d;
				if (!control_q[async_serial_pkg::CTL_RX_ENABLE]) begin
					rx_state_q <= async_serial_pkg::RX_IDLE;
					rx_ones_q  <= 2'h0;
				end else begin
					unique case (rx_state_q)
						async_serial_pkg::RX_IDLE: begin
							rx_ones_q <= rx_level_q ? ((rx_ones_q == 2'h3) ? 2'h3
							                                               : rx_ones_q + 2'h1)
							                        : 2'h0;
							if (!rx_level_q && rx_ones_q == 2'h3) begin
								rx_state_q <= async_serial_pkg::RX_START;
								rx_rt_q    <= async_serial_pkg::POS_FIRST;
								rx_noise_q <= 1'b0;
								rx_bit_q   <= 4'h0;
							end
						end
						async_serial_pkg::RX_START: begin
							rx_rt_q <= rx_pos;
							if (rx_pos == async_serial_pkg::POS_VERIFY1 ||
							    rx_pos == async_serial_pkg::POS_VERIFY2 ||
							    rx_pos >= async_serial_pkg::POS_VERIFY3 &&
							    rx_pos <= async_serial_pkg::POS_VOTE3)
								rx_samp_q <= rx_samp_d;
							if (rx_pos == async_serial_pkg::POS_VERIFY3) begin
								if (majority3(rx_samp_d)) begin
									rx_state_q <= async_serial_pkg::RX_IDLE;
									rx_ones_q  <= 2'h0;
								end else if (|rx_samp_d)
									rx_noise_q <= 1'b1;
							end
							if (rx_pos == async_serial_pkg::POS_VOTE3 && |rx_samp_d)
								rx_noise_q <= 1'b1;
							if (rx_pos == async_serial_pkg::POS_LAST) begin
								rx_state_q <= async_serial_pkg::RX_DATA;
								rx_last_q  <= 1'b0;
							end
						end
						async_serial_pkg::RX_DATA, async_serial_pkg::RX_STOP: begin
							rx_rt_q <= rx_pos;
							if (rx_pos >= async_serial_pkg::POS_VOTE1 &&
							    rx_pos <= async_serial_pkg::POS_VOTE3)
								rx_samp_q <= rx_samp_d;
							if (rx_pos == async_serial_pkg::POS_VOTE3) begin
								rx_cur_q <= majority3(rx_samp_d);
								if (disagree3(rx_samp_d))
									rx_noise_q <= 1'b1;
							end
							// Realign on a 1-to-0 data change to the edge actually seen.
							if (rx_state_q == async_serial_pkg::RX_DATA &&
							    rx_pos == async_serial_pkg::POS_VOTE3 && rx_last_q &&
							    !majority3(rx_samp_d) && rx_age_d <= async_serial_pkg::POS_LAST)
								rx_rt_q <= rx_age_d;
							if (rx_state_q == async_serial_pkg::RX_DATA &&
							    rx_pos == async_serial_pkg::POS_LAST) begin
								rx_shift_q <= {rx_cur_q, rx_shift_q[8:1]};
								rx_last_q  <= rx_cur_q;
								rx_bit_q   <= rx_bit_q + 4'h1;
								if (rx_bit_q == (nine_bit ? 4'h8 : 4'h7))
									rx_state_q <= async_serial_pkg::RX_STOP;
							end
							if (rx_state_q == async_serial_pkg::RX_STOP &&
							    rx_pos == async_serial_pkg::POS_VOTE3) begin
								rx_done_q  <= 1'b1;
								rx_fe_q    <= !majority3(rx_samp_d);
								rx_nf_q    <= rx_noise_q | disagree3(rx_samp_d);
								rx_brk_q   <= !majority3(rx_samp_d) && rx_word == 9'h000;
								rx_data_q  <= rx_word;
								rx_state_q <= async_serial_pkg::RX_IDLE;
								rx_ones_q  <= majority3(rx_samp_d) ? 2'h3 : 2'h0;
							end
						end
						default: rx_state_q <= async_serial_pkg::RX_IDLE;
					endcase
				end
			end
		end
	end

	// Checking helpers: ticks since the start edge and whether a realignment moved the count.
	logic [7:0] chk_span_q;
	logic       chk_resync_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			chk_span_q   <= 8'h00;
			chk_resync_q <= 1'b0;
		end else if (tick_q) begin
			if (rx_state_q == async_serial_pkg::RX_IDLE) begin
				chk_span_q   <= 8'h01;
				chk_resync_q <= 1'b0;
			end else begin
				chk_span_q <= (chk_span_q == 8'hFF) ? chk_span_q : chk_span_q + 8'h01;
				// Only a realignment that moves the count spoils the fixed stop position.
				if (rx_state_q == async_serial_pkg::RX_DATA &&
				    rx_pos == async_serial_pkg::POS_VOTE3 && rx_last_q &&
				    !majority3(rx_samp_d) && rx_age_d <= async_serial_pkg::POS_LAST &&
				    rx_age_d != rx_pos)
					chk_resync_q <= 1'b1;
			end
		end
	end

	property p_tx_start_level;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_load |=> ##1 serial_out == control_q[async_serial_pkg::CTL_TX_INVERT];
	endproperty
	a_tx_start_level: assert property (p_tx_start_level) else $error("start level wrong");

	property p_tx_empty_set;
		@(posedge clk_sys) disable iff (!rst_n)
		tx_load |=> status_q[async_serial_pkg::ST_TX_EMPTY] ##1
		(irq == mask_q[async_serial_pkg::ST_TX_EMPTY] || $past(mask_q) != mask_q ||
		 |(status_q & mask_q & 6'h3E) || |($past(status_q) & mask_q & 6'h3E));
	endproperty
	a_tx_empty_set: assert property (p_tx_empty_set) else $error("empty flag or irq");

	property p_tx_complete;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(status_q[async_serial_pkg::ST_TX_COMPLETE]) |-> !tx_busy_q && !$past(tx_buf_full_q);
	endproperty
	a_tx_complete: assert property (p_tx_complete) else $error("complete while busy");

	property p_ninth_copy;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_done_q && !nine_bit |-> rx_data_q[8] == rx_data_q[7];
	endproperty
	a_ninth_copy: assert property (p_ninth_copy) else $error("ninth bit not copy");

	property p_rx_full;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_done_q |=> status_q[async_serial_pkg::ST_RX_FULL] &&
		              status_q[async_serial_pkg::ST_FRAMING] == rx_fe_q;
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("full or framing flag");

	property p_start_found;
		@(posedge clk_sys) disable iff (!rst_n)
		tick_q && rx_state_q == async_serial_pkg::RX_IDLE && !rx_level_q &&
		rx_ones_q == 2'h3 && control_q[async_serial_pkg::CTL_RX_ENABLE]
		|=> rx_state_q == async_serial_pkg::RX_START && rx_rt_q == 5'h01;
	endproperty
	a_start_found: assert property (p_start_found) else $error("start not taken");

	property p_start_abort;
		@(posedge clk_sys) disable iff (!rst_n)
		tick_q && rx_state_q == async_serial_pkg::RX_START && rx_pos == 5'h07 &&
		majority3(rx_samp_d) |=> rx_state_q == async_serial_pkg::RX_IDLE;
	endproperty
	a_start_abort: assert property (p_start_abort) else $error("bad start kept");

	property p_stop_tick_8bit;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_done_q && !nine_bit && !chk_resync_q |-> chk_span_q == 8'd154;
	endproperty
	a_stop_tick_8bit: assert property (p_stop_tick_8bit) else $error("stop sample off");

	property p_break;
		@(posedge clk_sys) disable iff (!rst_n)
		rx_done_q && rx_brk_q |-> rx_data_q == 9'h000 && rx_fe_q ##1
		status_q[async_serial_pkg::ST_BREAK];
	endproperty
	a_break: assert property (p_break) else $error("break handling");

endmodule

//--- async_serial_unit_test.sv
`timescale 1ns/1ps
// Register-level bench: bus tasks, a model sender on the receive line, serial_out watched.
module async_serial_unit_test;
	logic        clk_sys, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, serial_in, serial_out, irq;
	logic        send, nine, stop_level, runt, busy;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, glitch_bit;
	logic [4:0]  glitch_at, bit_len;
	logic [1:0]  bresp, rresp;
	logic [8:0]  char_bits;
	int          n_fail, n_compared, k;

	async_serial_unit dut (.clk_sys, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .serial_in, .serial_out, .irq);
	remote_tx_model sender (.clk_sys, .rst_n, .send, .char_bits, .nine, .stop_level,
		.glitch_bit, .glitch_at, .bit_len, .runt, .serial_in, .busy);

	// Free-running system clock, 8 ns period.
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic complete_run;
		if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// One write; address and data are offered together and each dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = async_serial_pkg::RESP_OKAY);
		int i;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		check({30'h0, bvalid ? bresp : 2'h3}, {30'h0, er});
	endtask

	// One read; masked data and response are compared with what is expected.
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
		input logic [1:0] er = async_serial_pkg::RESP_OKAY);
		int i;
		araddr  <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		check(rdata & m, ed);
		check({30'h0, rvalid ? rresp : 2'h3}, {30'h0, er});
	endtask

	// Sends one byte and checks each level on serial_out at mid-bit.
	task automatic tx_case(input logic inv, input logic [7:0] b);
		logic [9:0] f;
		int i;
		f = {1'b1, b, 1'b0} ^ {10{inv}};
		wr(async_serial_pkg::ADDR_CONTROL_ONE, {28'h0, 3'h6, inv});
		wr(async_serial_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
		check(serial_out, f[9]);
		wr(async_serial_pkg::ADDR_DATA_BUFFER, {24'h0, b});
		// The interrupt output follows the status one clock later.
		@(posedge clk_sys);
		check(irq, 1'b0);
		for (i = 0; i < 100 && serial_out === f[9]; i++) @(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
		for (i = 0; i < 10; i++) begin
			check(serial_out, f[i]);
			repeat (16) @(posedge clk_sys);
		end
		for (i = 0; i < 50 && irq !== 1'b1; i++) @(posedge clk_sys);
		check(irq, 1'b1);
		rdc(async_serial_pkg::ADDR_STATUS_ONE, 32'h0000_0003, 32'h0000_0003);
	endtask

	// Receives one character from the model; checks timing, data, flags and interrupt.
	task automatic rx_case(input logic [8:0] c, input logic n9, input logic stp,
		input logic [3:0] gb, input logic [4:0] ga, input logic [4:0] len,
		input logic [31:0] wd, input logic [31:0] ws);
		int i;
		char_bits  <= c;
		nine       <= n9;
		stop_level <= stp;
		glitch_bit <= gb;
		glitch_at  <= ga;
		bit_len    <= len;
		send       <= 1'b1;
		@(posedge clk_sys);
		send <= 1'b0;
		for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk_sys);
		if (len == 5'h10) check(i >= 157 + 16 * n9 && i <= 162 + 16 * n9, 1'b1);
		rdc(async_serial_pkg::ADDR_DATA_BUFFER, 32'h0000_01FF, wd);
		rdc(async_serial_pkg::ADDR_STATUS_ONE, 32'h0000_003C, ws);
		wr(async_serial_pkg::ADDR_STATUS_ONE, 32'h0000_003C);
		@(posedge clk_sys);
		check(irq, 1'b0);
	endtask

	// Limits the run; the whole sequence needs well under 5000 clocks.
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		$display("BAD %0t run did not finish", $time);
		complete_run();
	end

	// Main sequence: reset values, transmitter, then the receiver cases.
	initial begin
		rst_n = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		wstrb = 4'hF;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		send = 1'b0;
		nine = 1'b0;
		stop_level = 1'b1;
		runt = 1'b0;
		char_bits = 9'h000;
		glitch_bit = 4'hF;
		glitch_at = 5'h00;
		bit_len = 5'h10;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rdc(async_serial_pkg::ADDR_CONTROL_ONE, 32'hFFFF_FFFF, 32'h0);
		rdc(async_serial_pkg::ADDR_STATUS_ONE, 32'hFFFF_FFFF, 32'h3);
		rdc(async_serial_pkg::ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
		rdc(async_serial_pkg::ADDR_BAUD_DIV, 32'hFFFF_FFFF, 32'h42);
		rdc(8'h14, 32'hFFFF_FFFF, 32'h0, async_serial_pkg::RESP_SLVERR);
		wr(8'h14, 32'h1, async_serial_pkg::RESP_SLVERR);
		wr(async_serial_pkg::ADDR_BAUD_DIV, 32'h0);
		wr(async_serial_pkg::ADDR_IRQ_MASK, 32'h1);
		@(posedge clk_sys);
		check(irq, 1'b1);
		tx_case(1'b0, 8'hA5);
		tx_case(1'b1, 8'h3C);
		wr(async_serial_pkg::ADDR_CONTROL_ONE, 32'h8);
		wr(async_serial_pkg::ADDR_IRQ_MASK, 32'h4);
		wr(async_serial_pkg::ADDR_STATUS_ONE, 32'h3F);
		runt <= 1'b1;
		send <= 1'b1;
		@(posedge clk_sys);
		send <= 1'b0;
		runt <= 1'b0;
		for (k = 0; k < 250 && irq !== 1'b1; k++) @(posedge clk_sys);
		rdc(async_serial_pkg::ADDR_STATUS_ONE, 32'h3C, 32'h0);
		rx_case(9'h03C, 0, 1, 4'hF, 0, 16, 32'h03C, 32'h04);
		rx_case(9'h0C3, 0, 1, 4'hF, 0, 16, 32'h1C3, 32'h04);
		rx_case(9'h025, 0, 1, 4'h0, 4, 16, 32'h025, 32'h0C);
		rx_case(9'h025, 0, 1, 4'h0, 8, 16, 32'h025, 32'h0C);
		rx_case(9'h025, 0, 1, 4'h3, 9, 16, 32'h025, 32'h0C);
		rx_case(9'h025, 0, 1, 4'h9, 6, 16, 32'h025, 32'h0C);
		rx_case(9'h0DA, 0, 0, 4'hF, 0, 16, 32'h1DA, 32'h14);
		rx_case(9'h000, 0, 0, 4'hF, 0, 16, 32'h000, 32'h34);
		rx_case(9'h055, 0, 1, 4'hF, 0, 18, 32'h055, 32'h04);
		wr(async_serial_pkg::ADDR_CONTROL_ONE, 32'hA);
		rx_case(9'h1A5, 1, 1, 4'hF, 0, 16, 32'h1A5, 32'h04);
		complete_run();
	end
endmodule

//--- remote_tx_model.sv
`timescale 1ns/1ps
// Far-end sender: one frame per send pulse, start bit, data LSB first, then stop.
// A two-clock glitch can start on any clock but the last of any bit (a single clock would be
// swallowed by the receiver's pin filter), and the bit length can be
// stretched so that a slow sender is imitated.
module remote_tx_model (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       send,
	input  wire logic [8:0] char_bits,
	input  wire logic       nine,
	input  wire logic       stop_level,
	input  wire logic [3:0] glitch_bit,
	input  wire logic [4:0] glitch_at,
	input  wire logic [4:0] bit_len,
	input  wire logic       runt,
	output logic            serial_in,
	output logic            busy
);
	logic [10:0] frame_q;
	logic [3:0]  bit_q;
	logic [4:0]  tick_q;
	logic        runt_q;

	// Between frames the line rests at its pulled-up mark level.
	assign serial_in = !busy || (frame_q[bit_q] ^ (bit_q == glitch_bit &&
	                   (tick_q == glitch_at || tick_q == glitch_at + 5'h01)));

	// Frame sequencer; a runt is a start level held for two clocks only.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
		end else if (!busy) begin
			busy    <= send;
			frame_q <= nine ? {stop_level, char_bits, 1'b0} : {1'b1, stop_level, char_bits[7:0], 1'b0};
			bit_q   <= 4'h0;
			tick_q  <= 5'h00;
			runt_q  <= runt;
		end else if (runt_q && tick_q == 5'h01) begin
			busy <= 1'b0;
		end else if (tick_q == bit_len - 5'h01) begin
			tick_q <= 5'h00;
			bit_q  <= bit_q + 4'h1;
			busy   <= bit_q != (nine ? 4'hA : 4'h9);
		end else begin
			tick_q <= tick_q + 5'h01;
		end
	end
endmodule
